/* verilog/cbo_pkg.sv */
// Package: option byte fields, reset values and timing constants
package cbo_pkg;
   // Option byte field positions
   localparam int BO_DETECT_BIT     = 7;
   localparam int BO_RESET_BIT      = 4;
   localparam int WD_OPTION_BIT     = 7;
   localparam int CLK_FILTER_BIT    = 4;
   localparam int RC_FREQ_BIT       = 3;
   localparam int SRC_SEL_HI_BIT    = 1;
   localparam int SRC_SEL_LO_BIT    = 0;
   localparam int DB_EXTEND_BIT     = 7;
   localparam int DB_LENGTH_BIT     = 6;
   localparam int SYS_HALVE_BIT     = 0;
   // Unprogrammed (erased) option byte value
   localparam logic [7:0] OPT_ERASED = 8'hFF;
   // Debounce lengths in system clocks
   localparam logic [5:0] DB_SHORT   = 6'h08;
   localparam logic [5:0] DB_MID     = 6'h10;
   localparam logic [5:0] DB_LONG    = 6'h20;
   // Internal RC output frequencies, kHz
   localparam int RC_FULL_KHZ       = 22118;
   localparam int RC_HALF_KHZ       = 11059;
   // Clock source codes
   typedef enum logic [1:0] {
      CBO_SRC_XTAL = 2'b00,
      CBO_SRC_UNDEF = 2'b01,
      CBO_SRC_RSVD = 2'b10,
      CBO_SRC_RC   = 2'b11
   } cbo_src_t;
   // Loader states
   typedef enum logic [1:0] {
      CBO_ST_IDLE   = 2'b00,
      CBO_ST_SAMPLE = 2'b01,
      CBO_ST_SETTLE = 2'b10,
      CBO_ST_RUN    = 2'b11
   } cbo_state_t;
   localparam logic [2:0] SETTLE_CYCLES = 3'h4;
endpackage : cbo_pkg

/* verilog/cbo_debounce.sv */
// Reset pin debouncer with selectable stable length
`timescale 1ns/1ps
module cbo_debounce
   import cbo_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       pin_n,
   input  wire logic [5:0] length,
   input  wire logic       sys_en,
   output logic            pin_reset
);
   logic [5:0] cnt_r;
   logic       last_r;

   // Counts only on system clock enables so length is in system clocks
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_r     <= 6'h00;
         last_r    <= 1'b1;
         pin_reset <= 1'b0;
      end else if (sys_en) begin
         last_r <= pin_n;
         if (pin_n != last_r) begin
            cnt_r <= 6'h00;
         end else if (cnt_r + 6'h01 >= length) begin
            pin_reset <= !pin_n;
         end else begin
            cnt_r <= cnt_r + 6'h01;
         end
      end
   end
endmodule : cbo_debounce

/* verilog/cbo_clkdiv.sv */
// System clock enable divider: full or half rate
`timescale 1ns/1ps
module cbo_clkdiv (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic halve,
   output logic      sys_en
);
   logic phase_r;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         phase_r <= 1'b0;
      end else begin
         phase_r <= !phase_r;
      end
   end

   // Halving drops every other cycle
   assign sys_en = halve ? phase_r : 1'b1;
endmodule : cbo_clkdiv

/* verilog/cbo_decoder.sv */
// Option byte decoder and run-time control bit loader
`timescale 1ns/1ps
module cbo_decoder
   import cbo_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [7:0] brownout_option_byte,
   input  wire logic [7:0] watchdog_clock_option_byte,
   input  wire logic [7:0] reset_debounce_divider_option_byte,
   input  wire logic       reset_event,
   input  wire logic       sw_reset,
   input  wire logic       supply_low,
   input  wire logic       reset_pin_n,
   input  wire logic       detect_wr,
   input  wire logic       detect_wdata,
   input  wire logic       watchdog_wr,
   input  wire logic       watchdog_wdata,
   output logic            brownout_detect_enable,
   output logic            watchdog_enable,
   output logic            brownout_reset,
   output logic            clock_filter_on,
   output logic            rc_full_rate,
   output logic            src_is_rc,
   output logic            src_is_xtal,
   output logic            src_invalid,
   output logic            sysclk_halved,
   output logic            system_clock_en,
   output logic [5:0]      debounce_length,
   output logic            pin_reset,
   output logic            core_reset_n
);
   cbo_state_t state_r;
   cbo_state_t state_nxt;
   logic [7:0] bo_r;
   logic [7:0] wd_r;
   logic [7:0] db_r;
   logic [2:0] settle_r;
   logic       load_mirrors;
   logic       any_reset;
   cbo_src_t   src;
   logic       first_load_r;
   logic       sw_seen_r;

   ////////////////////////////////////////////////////////////////
   // Debounce length decode, used for the registered output
   function automatic logic [5:0] db_len(input logic [7:0] opt);
      if (opt[DB_EXTEND_BIT]) begin
         db_len = DB_SHORT;
      end else if (opt[DB_LENGTH_BIT]) begin
         db_len = DB_MID;
      end else begin
         db_len = DB_LONG;
      end
   endfunction : db_len

   ////////////////////////////////////////////////////////////////
   // Loader sequence
   // Resets outside RUN are dropped; a new load starts only from RUN
   assign any_reset = reset_event | sw_reset;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CBO_ST_IDLE: begin
            state_nxt = CBO_ST_SAMPLE;
         end
         CBO_ST_SAMPLE: begin
            state_nxt = CBO_ST_SETTLE;
         end
         CBO_ST_SETTLE: begin
            if (settle_r == SETTLE_CYCLES) begin
               state_nxt = CBO_ST_RUN;
            end
         end
         CBO_ST_RUN: begin
            if (any_reset) begin
               state_nxt = CBO_ST_SAMPLE;
            end
         end
         default: begin
            state_nxt = CBO_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r <= CBO_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         settle_r <= 3'h0;
      end else if (state_r == CBO_ST_SETTLE) begin
         settle_r <= settle_r + 3'h1;
      end else begin
         settle_r <= 3'h0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Option sampling; bytes are caught after release, not at reset
   // brown-out byte sample
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bo_r <= OPT_ERASED;
      end else if (state_r == CBO_ST_SAMPLE) begin
         bo_r <= brownout_option_byte;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wd_r <= OPT_ERASED;
      end else if (state_r == CBO_ST_SAMPLE) begin
         wd_r <= watchdog_clock_option_byte;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         db_r <= OPT_ERASED;
      end else if (state_r == CBO_ST_SAMPLE) begin
         db_r <= reset_debounce_divider_option_byte;
      end
   end

   // Registered from next state so release lines up with RUN
   // core held until settled
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         core_reset_n <= 1'b0;
      end else begin
         core_reset_n <= (state_nxt == CBO_ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////
   // Run-time mirrors; power-up counts as a load, later only on
   // software reset, so other resets keep software's values
   // reload only on software reset
   assign load_mirrors = (state_r == CBO_ST_SETTLE) &&
                         (settle_r == 3'h0) &&
                         (first_load_r || sw_seen_r);

   // Software writes wait for core release; the reload slot lies
   // inside the hold, so the two never meet in one cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         first_load_r <= 1'b1;
         sw_seen_r    <= 1'b0;
      end else begin
         if (load_mirrors) begin
            first_load_r <= 1'b0;
         end
         if (state_r == CBO_ST_RUN && any_reset) begin
            sw_seen_r <= sw_reset;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         brownout_detect_enable <= 1'b0;
      end else if (load_mirrors) begin
         brownout_detect_enable <= !bo_r[BO_DETECT_BIT];
      end else if (detect_wr && core_reset_n) begin
         brownout_detect_enable <= detect_wdata;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         watchdog_enable <= 1'b0;
      end else if (load_mirrors) begin
         watchdog_enable <= !wd_r[WD_OPTION_BIT];
      end else if (watchdog_wr && core_reset_n) begin
         watchdog_enable <= watchdog_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Brown-out reset gate
   // Also gated by the run-time enable, so software can mute it
   // reset only when option set
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         brownout_reset <= 1'b0;
      end else begin
         brownout_reset <= supply_low && brownout_detect_enable &&
                           bo_r[BO_RESET_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Clock decode
   assign src = cbo_src_t'({wd_r[SRC_SEL_HI_BIT], wd_r[SRC_SEL_LO_BIT]});

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         clock_filter_on <= 1'b1;
      end else begin
         clock_filter_on <= wd_r[CLK_FILTER_BIT];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rc_full_rate <= 1'b1;
      end else begin
         rc_full_rate <= wd_r[RC_FREQ_BIT];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         src_is_rc <= 1'b1;
      end else begin
         src_is_rc <= (src == CBO_SRC_RC);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         src_is_xtal <= 1'b0;
      end else begin
         src_is_xtal <= (src == CBO_SRC_XTAL);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         src_invalid <= 1'b0;
      end else begin
         src_invalid <= (src == CBO_SRC_RSVD) ||
                        (src == CBO_SRC_UNDEF);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sysclk_halved <= 1'b0;
      end else begin
         sysclk_halved <= !db_r[SYS_HALVE_BIT];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         debounce_length <= DB_SHORT;
      end else begin
         debounce_length <= db_len(db_r);
      end
   end

   ////////////////////////////////////////////////////////////////
   cbo_clkdiv u_clkdiv (
      .mclk   (mclk),
      .nrst   (nrst),
      .halve  (sysclk_halved),
      .sys_en (system_clock_en)
   );

   cbo_debounce u_debounce (
      .mclk      (mclk),
      .nrst      (nrst),
      .pin_n     (reset_pin_n),
      .length    (debounce_length),
      .sys_en    (system_clock_en),
      .pin_reset (pin_reset)
   );
endmodule : cbo_decoder

/* tb/cbo_decoder_props.sv */
// Checker: option decode and core release properties
`timescale 1ns/1ps
module cbo_decoder_props (
   input wire logic       mclk,
   input wire logic       nrst,
   input wire logic [7:0] brownout_option_byte,
   input wire logic [7:0] watchdog_clock_option_byte,
   input wire logic [7:0] reset_debounce_divider_option_byte,
   input wire logic       sw_reset,
   input wire logic       supply_low,
   input wire logic       brownout_detect_enable,
   input wire logic       brownout_reset,
   input wire logic       clock_filter_on,
   input wire logic       rc_full_rate,
   input wire logic       src_is_rc,
   input wire logic       src_is_xtal,
   input wire logic       sysclk_halved,
   input wire logic       system_clock_en,
   input wire logic [5:0] debounce_length,
   input wire logic       core_reset_n
);
   logic [7:0] wb;
   logic [7:0] db;
   logic [5:0] len_x;
   assign wb = watchdog_clock_option_byte;
   assign db = reset_debounce_divider_option_byte;
   assign len_x = db[7] ? 6'h08 : (db[6] ? 6'h10 : 6'h20);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   filter_sel_a: assert property ($rose(core_reset_n) |-> clock_filter_on == wb[4]) else $error("filter decode wrong");
   rc_rate_a: assert property ($rose(core_reset_n) |-> rc_full_rate == wb[3]) else $error("rc rate decode wrong");
   src_sel_a: assert property ($rose(core_reset_n) |-> src_is_rc == (wb[1:0] == 2'h3) && src_is_xtal == (wb[1:0] == 2'h0)) else $error("source decode wrong");
   db_length_a: assert property ($rose(core_reset_n) |-> debounce_length == len_x) else $error("debounce length wrong");
   sys_halve_a: assert property ($rose(core_reset_n) |-> sysclk_halved == !db[0]) else $error("halving decode wrong");
   half_rate_a: assert property (sysclk_halved && system_clock_en |=> !system_clock_en || !sysclk_halved) else $error("enable not halved");
   full_rate_a: assert property (!sysclk_halved |-> system_clock_en) else $error("enable missing at full rate");
   bo_reset_a: assert property (core_reset_n && $past(core_reset_n) |-> brownout_reset == $past(supply_low && brownout_detect_enable && brownout_option_byte[4])) else $error("brownout reset wrong");
   sw_hold_a: assert property (core_reset_n && sw_reset |-> ##[1:2] !core_reset_n) else $error("core not held");
   core_rel_a: assert property ($fell(core_reset_n) |-> ##[1:12] core_reset_n) else $error("core release late");
   sw_cov: cover property (core_reset_n && sw_reset);
   bo_cov: cover property (brownout_reset);
   half_cov: cover property ($rose(core_reset_n) && sysclk_halved);
endmodule : cbo_decoder_props

/* tb/cbo_option_store.sv */
// Option storage model: programmed option bytes
`timescale 1ns/1ps
module cbo_option_store (
   input  wire logic       mclk,
   input  wire logic       prog,
   input  wire logic [7:0] bo_in,
   input  wire logic [7:0] wd_in,
   input  wire logic [7:0] db_in,
   output logic      [7:0] bo_byte = 8'hFF,
   output logic      [7:0] wd_byte = 8'hFF,
   output logic      [7:0] db_byte = 8'hFF
);
   always @(posedge mclk) begin
      if (prog) begin
         bo_byte <= bo_in | 8'h2F;
         wd_byte <= wd_in | 8'h64;
         db_byte <= db_in | 8'h3E;
      end
   end
endmodule : cbo_option_store

/* tb/testbench.sv */
// Testbench: option decode, mirror reload and debounce
`timescale 1ns/1ps
module testbench;
   logic mclk = 0, nrst = 0, prog = 0, sw_reset = 0, reset_event = 0;
   logic supply_low = 0, reset_pin_n = 1, detect_wr = 0, detect_wdata = 0;
   logic watchdog_wr = 0, watchdog_wdata = 0;
   logic [7:0] bo_in = 0, wd_in = 0, db_in = 0, bb, wb, db, e8;
   logic bde, wde, fo, rf, rc, xt, iv, hv, se, pr, br, cr;
   logic [5:0] dl;
   logic [31:0] seed = 32'h4C;
   int miscompares = 0, checks = 0, n, k;
   cbo_option_store cbo_option_store_i (.mclk(mclk), .prog(prog),
      .bo_in(bo_in), .wd_in(wd_in), .db_in(db_in),
      .bo_byte(bb), .wd_byte(wb), .db_byte(db));
   cbo_decoder cbo_decoder_i (.mclk(mclk), .nrst(nrst),
      .brownout_option_byte(bb), .watchdog_clock_option_byte(wb),
      .reset_debounce_divider_option_byte(db), .reset_event(reset_event),
      .sw_reset(sw_reset), .supply_low(supply_low),
      .reset_pin_n(reset_pin_n), .detect_wr(detect_wr),
      .detect_wdata(detect_wdata), .watchdog_wr(watchdog_wr),
      .watchdog_wdata(watchdog_wdata), .brownout_detect_enable(bde),
      .watchdog_enable(wde), .brownout_reset(br), .clock_filter_on(fo),
      .rc_full_rate(rf), .src_is_rc(rc), .src_is_xtal(xt),
      .src_invalid(iv), .sysclk_halved(hv), .system_clock_en(se),
      .debounce_length(dl), .pin_reset(pr), .core_reset_n(cr));
   initial begin
      forever #10 mclk = ~mclk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [7:0] len_of(input logic [7:0] d);
      return d[7] ? 8'h08 : (d[6] ? 8'h10 : 8'h20);
   endfunction : len_of
   task automatic test_done();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic wait_core();
      repeat (2) @(posedge mclk);
      for (n = 0; n < 30 && cr !== 1'b1; n++) @(negedge mclk);
      if (cr !== 1'b1) begin
         miscompares++;
         test_done();
      end
      @(posedge mclk);
   endtask : wait_core
   // Program bytes, then one reset pulse
   task automatic load(input logic [23:0] v, input logic sw);
      @(posedge mclk);
      {bo_in, wd_in, db_in} <= v;
      prog <= 1;
      @(posedge mclk);
      prog <= 0;
      sw_reset <= sw;
      reset_event <= !sw;
      @(posedge mclk);
      sw_reset <= 0;
      reset_event <= 0;
      wait_core();
   endtask : load
   task automatic chk_dec(input logic [7:0] w, input logic [7:0] d);
      chk("filter", w[4], fo);
      chk("rc_full", w[3], rf);
      chk("src", {w[1:0] == 2'h3, w[1:0] == 2'h0, w[1] ^ w[0]}, {rc, xt, iv});
      chk("halved", !d[0], hv);
      chk("db_len", len_of(d), {2'h0, dl});
   endtask : chk_dec
   initial begin
      repeat (2) @(posedge mclk);
      nrst <= 1;
      wait_core();
      chk_dec(8'hFF, 8'hFF);
      chk("bo_en", 8'h00, bde);
      chk("wd_en", 8'h00, wde);
      for (int i = 0; i < 24; i++) begin
         e8 = 8'(xs());
         if (i < 4) e8 = {i[1:0], 6'h00};
         load({16'(xs()), e8}, 1'b1);
         chk_dec(wd_in | 8'h64, e8 | 8'h3E);
         chk("bo_en", !bo_in[7], bde);
         chk("wd_en", !wd_in[7], wde);
         @(posedge mclk);
         detect_wr <= 1;
         detect_wdata <= bo_in[7];
         watchdog_wr <= 1;
         watchdog_wdata <= wd_in[7];
         @(posedge mclk);
         detect_wr <= 0;
         watchdog_wr <= 0;
         @(posedge mclk);
         chk("bo_wr", detect_wdata, bde);
         chk("wd_wr", watchdog_wdata, wde);
         load(24'(xs()), 1'b0);
         chk("bo_keep", detect_wdata, bde);
         chk("wd_keep", watchdog_wdata, wde);
         supply_low <= 1;
         repeat (3) @(posedge mclk);
         chk("bo_rst", bde & bo_in[4] | 8'h0, br);
         supply_low <= 0;
         reset_pin_n <= 0;
         k = len_of(db_in | 8'h3E) * (db_in[0] ? 1 : 2);
         for (n = 0; n < 80 && pr !== 1'b1; n++) @(negedge mclk);
         chk("db_time", 8'h01, n >= k - 1 && n <= k + 3);
         @(posedge mclk);
         reset_pin_n <= 1;
         for (n = 0; n < 80 && pr !== 1'b0; n++) @(negedge mclk);
         chk("db_free", 8'h01, n >= k - 1 && n <= k + 3);
         repeat (4) @(posedge mclk);
      end
      test_done();
   end
endmodule : testbench
bind cbo_decoder cbo_decoder_props cbo_decoder_props_i (.*);
